// ===== design/ufl_ctrl.sv
/*
 Control logic of one asynchronous serial channel: FIFO control, line format and
 modem control registers behind an AHB-Lite slave, plus trigger events, line
 format decode, break, infrared routing, prescaler and send-immediate arbitration.
 Assumes a single hclk domain; FIFO levels, shifter status and serial pins come
 from the surrounding channel datapath; pins are synchronised here.
*/
`timescale 1ns/1ps
// Notes on behaviour
// R1: TX event when count falls below trigger
// R2: TX event also when FIFO empties
// R3: RX event when count crosses trigger
// R4: Store legacy transfer-mode bit, no effect
// R5: TX FIFO reset pulse, needs enable
// R6: RX FIFO reset pulse, needs enable
// R7: Other FIFO bits ignored without enable
// R8: Divisor access bit selects divisor registers
// R9: Break holds transmit output low
// R10: Decode parity none/odd/even/one/zero; odd and even both give the one calculated code
// R11: Parity format shared by transmit and receive
// R12: Stop bits one, one-half or two
// R13: Word length five to eight bits
// R14: Prescaler divides clock by four
// R15: Infrared bit loaded from strap at reset
// R16: Infrared routing, idle output low
// R17: Optional receive inversion before decoder
// R18: Any character resumes suspended transmission
// R19: Loopback; send-immediate drives carrier detect
// R20: Next holding write sent ahead, self-clears
// R21: Host writes immediate byte next
// R22: Flow characters precede immediate byte
// R23: Host keeps transmitter enabled, clears bit
module ufl_ctrl #(
  parameter int FIFO_DEPTH = 16,
  parameter int CNT_W = 5
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic infrared_strap_pin,
  input wire logic [CNT_W-1:0] tx_fifo_count,
  input wire logic [CNT_W-1:0] rx_fifo_count,
  input wire logic rx_char_done,
  input wire logic flow_char_pending,
  input wire logic shifter_load,
  input wire logic tx_serial,
  input wire logic ir_tx_encoded,
  input wire logic rx_pin,
  output logic tx_pin,
  output logic rx_to_core,
  output logic rx_to_ir_decoder,
  output logic tx_event,
  output logic rx_event,
  output logic tx_fifo_clear,
  output logic rx_fifo_clear,
  output logic fifo_enable,
  output logic [3:0] data_bits,
  output logic [1:0] parity_mode,
  output logic [1:0] stop_mode,
  output logic baud_tick_en,
  output logic xon_resume,
  output logic loopback,
  output logic loop_carrier_detect,
  output logic [1:0] tx_source,
  output logic [7:0] imm_byte,
  output logic [7:0] thr_byte,
  output logic thr_write,
  output logic [7:0] div_low,
  output logic [7:0] div_high,
  output logic [7:0] div_frac
);
  logic [7:0] fifo_ctrl_q;
  logic [7:0] line_fmt_q;
  logic [7:0] modem_ctrl_q;
  logic [7:0] feature_q;
  logic [7:0] imm_q;
  logic imm_valid_q;
  logic strap_s1_q, strap_s2_q;
  logic rx_s1_q, rx_s2_q;
  logic strap_load_q;
  logic ph_wr_q, ph_rd_q;
  logic [7:0] ph_addr_q;
  logic [CNT_W-1:0] tx_cnt_prev_q, rx_cnt_prev_q;
  logic tx_above_q;
  logic [1:0] pre_cnt_q;
  logic [4:0] trig;
  logic acc;
  logic wr_fc, wr_lf, wr_mc, wr_ft, wr_data, wr_divh, wr_txc;
  logic [7:0] wb;
  logic ir_rx;

  assign acc = hsel & hready & htrans[1];
  assign wb = hwdata[7:0];
  assign wr_fc = ph_wr_q & (ph_addr_q == ufl_pkg::OFS_FIFO_CTRL);
  assign wr_lf = ph_wr_q & (ph_addr_q == ufl_pkg::OFS_LINE_FMT);
  assign wr_mc = ph_wr_q & (ph_addr_q == ufl_pkg::OFS_MODEM_CTRL);
  assign wr_ft = ph_wr_q & (ph_addr_q == ufl_pkg::OFS_FEATURE);
  assign wr_data = ph_wr_q & (ph_addr_q == ufl_pkg::OFS_DATA);
  assign wr_divh = ph_wr_q & (ph_addr_q == ufl_pkg::OFS_DIV_HIGH);
  assign wr_txc = ph_wr_q & (ph_addr_q == ufl_pkg::OFS_TX_CTRL);

  // Bus address phase capture; zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_q <= 1'b0;
      ph_rd_q <= 1'b0;
      ph_addr_q <= 8'h00;
    end else if (hready) begin
      ph_wr_q <= acc & hwrite;
      ph_rd_q <= acc & ~hwrite;
      ph_addr_q <= {haddr[7:2], 2'b00};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Read data registered in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (acc & ~hwrite) begin
      case ({haddr[7:2], 2'b00})
        ufl_pkg::OFS_DATA: hrdata <= {24'h00_0000, line_fmt_q[ufl_pkg::LF_DIV] ? div_low : 8'h00}; // [R8]
        ufl_pkg::OFS_DIV_HIGH: hrdata <= {24'h00_0000, line_fmt_q[ufl_pkg::LF_DIV] ? div_high : 8'h00};
        ufl_pkg::OFS_LINE_FMT: hrdata <= {24'h00_0000, line_fmt_q};
        ufl_pkg::OFS_MODEM_CTRL: hrdata <= {24'h00_0000, modem_ctrl_q};
        ufl_pkg::OFS_FEATURE: hrdata <= {24'h00_0000, feature_q};
        ufl_pkg::OFS_STATUS: hrdata <= {26'h000_0000, imm_valid_q, tx_above_q,
                                        rx_event, tx_event, fifo_enable, loopback};
        ufl_pkg::OFS_TX_CTRL: hrdata <= {24'h00_0000, line_fmt_q[ufl_pkg::LF_DIV] ? div_frac : 8'h00};
        default: hrdata <= 32'h0000_0000;
      endcase
    end else begin
      hrdata <= 32'h0000_0000;
    end
  end

  // FIFO control: write only, other bits need the enable bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fifo_ctrl_q <= ufl_pkg::FIFO_CTRL_RST;
    end else if (wr_fc) begin
      if (wb[ufl_pkg::FC_EN]) begin
        fifo_ctrl_q <= {wb[7:3], 2'b00, 1'b1}; // [R7] [R4]
      end else begin
        fifo_ctrl_q <= {fifo_ctrl_q[7:1], 1'b0}; // [R7]
      end
    end
  end

  // FIFO reset pulses, one cycle, self-clearing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_fifo_clear <= 1'b0;
      rx_fifo_clear <= 1'b0;
    end else begin
      tx_fifo_clear <= wr_fc & wb[ufl_pkg::FC_EN] & wb[ufl_pkg::FC_TXRST]; // [R5]
      rx_fifo_clear <= wr_fc & wb[ufl_pkg::FC_EN] & wb[ufl_pkg::FC_RXRST]; // [R6]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_fmt_q <= ufl_pkg::LINE_FMT_RST;
    end else if (wr_lf) begin
      line_fmt_q <= wb;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      feature_q <= ufl_pkg::FEATURE_RST;
    end else if (wr_ft) begin
      feature_q <= wb;
    end
  end

  // Strap synchroniser runs through reset so its level is settled at release
  always_ff @(posedge hclk) begin
    strap_s1_q <= infrared_strap_pin;
    strap_s2_q <= strap_s1_q;
  end

  // Receive pin synchroniser and strap load strobe
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      strap_load_q <= 1'b1;
    end else begin
      rx_s1_q <= rx_pin;
      rx_s2_q <= rx_s1_q;
      strap_load_q <= 1'b0;
    end
  end

  // Modem control; infrared bit caught from strap after reset release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      modem_ctrl_q <= ufl_pkg::MODEM_CTRL_RST;
    end else begin
      if (strap_load_q) begin
        modem_ctrl_q[ufl_pkg::MC_IR] <= strap_s2_q; // [R15]
      end
      if (wr_mc) begin
        modem_ctrl_q <= wb;
      end else if (wr_data & ~line_fmt_q[ufl_pkg::LF_DIV] & ~modem_ctrl_q[ufl_pkg::MC_LOOP]) begin
        modem_ctrl_q[ufl_pkg::MC_IMM] <= 1'b0; // [R20]
      end else if (ph_wr_q | ph_rd_q) begin
        if (~modem_ctrl_q[ufl_pkg::MC_LOOP]) begin
          modem_ctrl_q[ufl_pkg::MC_IMM] <= 1'b0; // [R21]
        end
      end
    end
  end

  // Divisors and holding writes steered by divisor access
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_low <= ufl_pkg::DIV_RST;
      div_high <= 8'h00;
      div_frac <= 8'h00;
      thr_byte <= 8'h00;
      thr_write <= 1'b0;
    end else begin
      thr_write <= 1'b0;
      if (wr_data & line_fmt_q[ufl_pkg::LF_DIV]) begin
        div_low <= wb; // [R8]
      end else if (wr_data & ~(modem_ctrl_q[ufl_pkg::MC_IMM] & ~modem_ctrl_q[ufl_pkg::MC_LOOP])) begin
        thr_byte <= wb;
        thr_write <= 1'b1;
      end
      if (wr_divh & line_fmt_q[ufl_pkg::LF_DIV]) begin
        div_high <= wb; // [R8]
      end
      if (wr_txc & line_fmt_q[ufl_pkg::LF_DIV]) begin
        div_frac <= wb; // [R8]
      end
    end
  end

  // Immediate byte capture and transmit source arbitration
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      imm_q <= 8'h00;
      imm_valid_q <= 1'b0;
      tx_source <= ufl_pkg::UFL_TX_IDLE;
    end else begin
      if (wr_data & ~line_fmt_q[ufl_pkg::LF_DIV] & modem_ctrl_q[ufl_pkg::MC_IMM]
          & ~modem_ctrl_q[ufl_pkg::MC_LOOP]) begin
        imm_q <= wb; // [R20]
        imm_valid_q <= 1'b1;
      end else if (shifter_load & ~flow_char_pending) begin
        imm_valid_q <= 1'b0;
      end
      if (flow_char_pending) begin
        tx_source <= ufl_pkg::UFL_TX_FLOW; // [R22]
      end else if (imm_valid_q) begin
        tx_source <= ufl_pkg::UFL_TX_IMM; // [R20]
      end else if (tx_fifo_count != '0) begin
        tx_source <= ufl_pkg::UFL_TX_FIFO;
      end else begin
        tx_source <= ufl_pkg::UFL_TX_IDLE;
      end
    end
  end

  // Trigger level; one table serves both directions
  always_comb begin
    case (fifo_ctrl_q[ufl_pkg::FC_TXTRG +: 2])
      2'b00: trig = ufl_pkg::TRG_1;
      2'b01: trig = ufl_pkg::TRG_4;
      2'b10: trig = ufl_pkg::TRG_8;
      default: trig = ufl_pkg::TRG_14;
    endcase
  end

  // Trigger events
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_cnt_prev_q <= '0;
      rx_cnt_prev_q <= '0;
      tx_above_q <= 1'b0;
      tx_event <= 1'b0;
      rx_event <= 1'b0;
    end else begin
      tx_cnt_prev_q <= tx_fifo_count;
      rx_cnt_prev_q <= rx_fifo_count;
      if (tx_fifo_count >= CNT_W'(trig)) begin
        tx_above_q <= 1'b1;
      end else if (tx_fifo_count < tx_cnt_prev_q) begin
        tx_above_q <= 1'b0;
      end
      tx_event <= fifo_ctrl_q[ufl_pkg::FC_EN] & (
        ((tx_cnt_prev_q >= CNT_W'(trig)) & (tx_fifo_count < CNT_W'(trig))) | // [R1]
        (~tx_above_q & (tx_cnt_prev_q != '0) & (tx_fifo_count == '0))); // [R2]
      rx_event <= fifo_ctrl_q[ufl_pkg::FC_EN] &
        (rx_cnt_prev_q < CNT_W'(trig)) & (rx_fifo_count >= CNT_W'(trig)); // [R3]
    end
  end

  // Line format decode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_bits <= ufl_pkg::WLEN_BASE;
      parity_mode <= ufl_pkg::UFL_PAR_NONE;
      stop_mode <= ufl_pkg::UFL_STOP_ONE;
    end else begin
      data_bits <= ufl_pkg::WLEN_BASE + {2'b00, line_fmt_q[ufl_pkg::LF_WLEN +: 2]}; // [R13]
      if (~line_fmt_q[ufl_pkg::LF_PEN]) begin
        parity_mode <= ufl_pkg::UFL_PAR_NONE; // [R10] [R11]
      end else if (~line_fmt_q[ufl_pkg::LF_FORCE]) begin
        parity_mode <= ufl_pkg::UFL_PAR_CALC;
      end else if (~line_fmt_q[ufl_pkg::LF_EVEN]) begin
        parity_mode <= ufl_pkg::UFL_PAR_ONE;
      end else begin
        parity_mode <= ufl_pkg::UFL_PAR_ZERO;
      end
      if (~line_fmt_q[ufl_pkg::LF_STOP]) begin
        stop_mode <= ufl_pkg::UFL_STOP_ONE; // [R12]
      end else if (line_fmt_q[ufl_pkg::LF_WLEN +: 2] == 2'b00) begin
        stop_mode <= ufl_pkg::UFL_STOP_ONE_HALF;
      end else begin
        stop_mode <= ufl_pkg::UFL_STOP_TWO;
      end
    end
  end

  // Prescaler enable for the baud generator
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_cnt_q <= 2'b00;
      baud_tick_en <= 1'b0;
    end else begin
      pre_cnt_q <= pre_cnt_q + 2'b01;
      baud_tick_en <= ~modem_ctrl_q[ufl_pkg::MC_PRE] | (pre_cnt_q == ufl_pkg::PRE_DIV4_LAST); // [R14]
    end
  end

  assign ir_rx = rx_s2_q ^ feature_q[ufl_pkg::FT_RXINV];

  // Pin routing: break, infrared, loopback
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_pin <= 1'b1;
      rx_to_core <= 1'b1;
      rx_to_ir_decoder <= 1'b1;
      xon_resume <= 1'b0;
      loopback <= 1'b0;
      loop_carrier_detect <= 1'b0;
      fifo_enable <= 1'b0;
    end else begin
      if (line_fmt_q[ufl_pkg::LF_BRK]) begin
        tx_pin <= 1'b0; // [R9]
      end else if (modem_ctrl_q[ufl_pkg::MC_LOOP]) begin
        tx_pin <= ~modem_ctrl_q[ufl_pkg::MC_IR];
      end else if (modem_ctrl_q[ufl_pkg::MC_IR]) begin
        tx_pin <= ir_tx_encoded; // [R16]
      end else begin
        tx_pin <= tx_serial;
      end
      rx_to_ir_decoder <= ir_rx; // [R17]
      if (modem_ctrl_q[ufl_pkg::MC_LOOP]) begin
        rx_to_core <= tx_serial; // [R19]
      end else begin
        rx_to_core <= rx_s2_q;
      end
      xon_resume <= modem_ctrl_q[ufl_pkg::MC_ANY] & rx_char_done; // [R18]
      loopback <= modem_ctrl_q[ufl_pkg::MC_LOOP];
      loop_carrier_detect <= modem_ctrl_q[ufl_pkg::MC_LOOP] & modem_ctrl_q[ufl_pkg::MC_IMM]; // [R19]
      fifo_enable <= fifo_ctrl_q[ufl_pkg::FC_EN];
    end
  end

  assign imm_byte = imm_q;
endmodule // ufl_ctrl

// ===== design/ufl_pkg.sv
/*
 Package for the serial channel control block: register offsets, field positions,
 reset values and small enumerations. Assumes nothing about its surroundings.
*/
package ufl_pkg;
  // Register byte offsets on the AHB-Lite bus
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_DIV_HIGH = 8'h04;
  localparam logic [7:0] OFS_FIFO_CTRL = 8'h08;
  localparam logic [7:0] OFS_LINE_FMT = 8'h0C;
  localparam logic [7:0] OFS_MODEM_CTRL = 8'h10;
  localparam logic [7:0] OFS_FEATURE = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_TX_CTRL = 8'h1C;
  // fifo_control_reg fields
  localparam int FC_EN = 0;
  localparam int FC_RXRST = 1;
  localparam int FC_TXRST = 2;
  localparam int FC_MODE = 3;
  localparam int FC_TXTRG = 4;
  localparam int FC_RXTRG = 6;
  // line_format_reg fields
  localparam int LF_WLEN = 0;
  localparam int LF_STOP = 2;
  localparam int LF_PEN = 3;
  localparam int LF_EVEN = 4;
  localparam int LF_FORCE = 5;
  localparam int LF_BRK = 6;
  localparam int LF_DIV = 7;
  // modem_line_control_reg fields
  localparam int MC_IMM = 3;
  localparam int MC_LOOP = 4;
  localparam int MC_ANY = 5;
  localparam int MC_IR = 6;
  localparam int MC_PRE = 7;
  // feature_control_reg field
  localparam int FT_RXINV = 4;
  // Reset values
  localparam logic [7:0] FIFO_CTRL_RST = 8'h00;
  localparam logic [7:0] LINE_FMT_RST = 8'h00;
  localparam logic [7:0] MODEM_CTRL_RST = 8'h00;
  localparam logic [7:0] FEATURE_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h01;
  // Trigger thresholds
  localparam logic [4:0] TRG_1 = 5'h01;
  localparam logic [4:0] TRG_4 = 5'h04;
  localparam logic [4:0] TRG_8 = 5'h08;
  localparam logic [4:0] TRG_14 = 5'h0E;
  // Prescaler count
  localparam logic [1:0] PRE_DIV4_LAST = 2'h3;
  // Data bits for word length code 0
  localparam logic [3:0] WLEN_BASE = 4'h5;

  typedef enum logic [1:0] {
    UFL_PAR_NONE = 2'b00,
    UFL_PAR_CALC = 2'b01,
    UFL_PAR_ONE = 2'b10,
    UFL_PAR_ZERO = 2'b11
  } ufl_par_t;

  typedef enum logic [1:0] {
    UFL_STOP_ONE = 2'b00,
    UFL_STOP_ONE_HALF = 2'b01,
    UFL_STOP_TWO = 2'b10
  } ufl_stop_t;

  typedef enum logic [1:0] {
    UFL_TX_IDLE = 2'b00,
    UFL_TX_FLOW = 2'b01,
    UFL_TX_IMM = 2'b10,
    UFL_TX_FIFO = 2'b11
  } ufl_txsel_t;
endpackage

// ===== bench/ufl_ctrl_assertions.sv
/*
 Checker for the serial channel control block.
 Sees only the top module's ports; bound to ufl_ctrl from tb.
*/
`timescale 1ns/1ps
module ufl_ctrl_chk #(
  parameter int CNT_W = 5
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic fifo_enable,
  input wire logic tx_fifo_clear,
  input wire logic rx_fifo_clear,
  input wire logic tx_event,
  input wire logic rx_event,
  input wire logic [CNT_W-1:0] tx_fifo_count,
  input wire logic [CNT_W-1:0] rx_fifo_count,
  input wire logic [3:0] data_bits,
  input wire logic [1:0] stop_mode,
  input wire logic [1:0] tx_source,
  input wire logic flow_char_pending,
  input wire logic loopback,
  input wire logic loop_carrier_detect
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_txclr; tx_fifo_clear |=> fifo_enable && !tx_fifo_clear; endproperty
  a_txclr: assert property (p_txclr) else $error("tx clear pulse wrong");
  property p_rxclr; rx_fifo_clear |=> fifo_enable && !rx_fifo_clear; endproperty
  a_rxclr: assert property (p_rxclr) else $error("rx clear pulse wrong");
  property p_txev;
    tx_event |-> fifo_enable && $past(tx_fifo_count) < $past(tx_fifo_count, 2);
  endproperty
  a_txev: assert property (p_txev) else $error("tx event without fall");
  property p_rxev;
    rx_event |-> fifo_enable && $past(rx_fifo_count) > $past(rx_fifo_count, 2);
  endproperty
  a_rxev: assert property (p_rxev) else $error("rx event without rise");
  property p_wlen; data_bits inside {[4'h5:4'h8]}; endproperty
  a_wlen: assert property (p_wlen) else $error("data bits out of range");
  property p_stop15; stop_mode == ufl_pkg::UFL_STOP_ONE_HALF |-> data_bits == 4'h5; endproperty
  a_stop15: assert property (p_stop15) else $error("half stop not 5 bits");
  property p_stop2; stop_mode == ufl_pkg::UFL_STOP_TWO |-> data_bits != 4'h5; endproperty
  a_stop2: assert property (p_stop2) else $error("two stops with 5 bits");
  property p_imm; tx_source == ufl_pkg::UFL_TX_IMM |-> !$past(flow_char_pending); endproperty
  a_imm: assert property (p_imm) else $error("immediate before flow");
  property p_loop; loop_carrier_detect |-> loopback; endproperty
  a_loop: assert property (p_loop) else $error("carrier out of loopback");
endmodule // ufl_ctrl_chk

// ===== bench/ufl_far_model.sv
/*
 Remote serial device on the line side.
 Sends one frame when asked; the line idles at mark as the shifter fills with ones.
*/
`timescale 1ns/1ps
module ufl_far_model #(
  parameter int BIT_CYC = 8
) (
  input wire logic hclk,
  input wire logic send,
  input wire logic [7:0] byte_in,
  output logic rx_line
);
  logic [9:0] sh_q = '1;
  int cnt_q = 0;
  assign rx_line = sh_q[0];
  always @(posedge hclk) begin
    if (send) begin
      sh_q <= {1'b1, byte_in, 1'b0};
      cnt_q <= 0;
    end else if (cnt_q == BIT_CYC - 1) begin
      sh_q <= {1'b1, sh_q[9:1]};
      cnt_q <= 0;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
endmodule // ufl_far_model

// ===== bench/tb.sv
/*
 Testbench for the serial channel control block.
 Drives AHB-Lite and datapath inputs, checks outputs; needs ufl_pkg.
*/
`timescale 1ns/1ps
module tb;
  logic hclk, hresetn, hsel, hwrite, hready, infrared_strap_pin, rx_char_done;
  logic flow_char_pending, shifter_load, tx_serial, ir_tx_encoded, rx_pin, send;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [4:0] tx_fifo_count, rx_fifo_count;
  logic hreadyout, hresp, tx_pin, rx_to_core, rx_to_ir_decoder, tx_event, rx_event;
  logic tx_fifo_clear, rx_fifo_clear, fifo_enable, baud_tick_en, xon_resume, loopback;
  logic loop_carrier_detect, thr_write;
  logic [3:0] data_bits;
  logic [1:0] parity_mode, stop_mode, tx_source;
  logic [7:0] imm_byte, thr_byte, div_low, div_high, div_frac;
  int n_errors, n_compared;
  int cnt[7];
  logic [6:0] pv;
  assign hready = hreadyout;
  assign pv = {baud_tick_en, xon_resume, thr_write, rx_fifo_clear, tx_fifo_clear, rx_event,
    tx_event};
  always @(negedge hclk) for (int k = 0; k < 7; k++) cnt[k] += pv[k];
  ufl_ctrl DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .infrared_strap_pin, .tx_fifo_count, .rx_fifo_count,
    .rx_char_done, .flow_char_pending, .shifter_load, .tx_serial, .ir_tx_encoded, .rx_pin,
    .tx_pin, .rx_to_core, .rx_to_ir_decoder, .tx_event, .rx_event, .tx_fifo_clear,
    .rx_fifo_clear, .fifo_enable, .data_bits, .parity_mode, .stop_mode, .baud_tick_en,
    .xon_resume, .loopback, .loop_carrier_detect, .tx_source, .imm_byte, .thr_byte,
    .thr_write, .div_low, .div_high, .div_frac);
  ufl_far_model FAR (.hclk(hclk), .send(send), .byte_in(8'h00), .rx_line(rx_pin));
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wt;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
      stop_test();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wt();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    rd = hrdata;
    chk(hresp, 1'b0, "hresp");
  endtask
  task automatic rst(input logic s);
    hresetn <= 1'b0;
    infrared_strap_pin <= s;
    cyc(20);
    hresetn <= 1'b1;
    cyc(3);
  endtask
  task automatic t_reset;
    chk(data_bits, 4'h5, "data_bits");
    chk(fifo_enable, 1'b0, "fifo_enable");
    bus(0, ufl_pkg::OFS_LINE_FMT, 0);
    chk(rd, ufl_pkg::LINE_FMT_RST, "line_fmt");
    bus(0, ufl_pkg::OFS_MODEM_CTRL, 0);
    chk(rd, ufl_pkg::MODEM_CTRL_RST, "modem_ctrl");
    bus(1, 8'h20, 32'hFF);
    bus(0, 8'h20, 0);
    chk(rd, 0, "unmapped");
    $display("reset test done");
  endtask
  task automatic t_fmt;
    for (int i = 0; i < 64; i++) begin
      bus(1, ufl_pkg::OFS_LINE_FMT, i);
      cyc(2);
      chk(data_bits, 4'h5 + i[1:0], "data_bits");
      chk(stop_mode, !i[2] ? 0 : (i[1:0] == 0 ? 1 : 2), "stop_mode");
      chk(parity_mode, !i[3] ? 0 : (i[5] ? 2 + i[4] : 1), "parity_mode");
      bus(0, ufl_pkg::OFS_LINE_FMT, 0);
      chk(rd, i, "line_fmt");
    end
    bus(1, ufl_pkg::OFS_LINE_FMT, 8'h43);
    cyc(12);
    chk(tx_pin, 1'b0, "tx_pin break");
    bus(1, ufl_pkg::OFS_LINE_FMT, 8'h03);
    cyc(2);
    chk(tx_pin, 1'b1, "tx_pin");
    $display("format test done");
  endtask
  task automatic t_div;
    cnt = '{default: 0};
    bus(1, ufl_pkg::OFS_LINE_FMT, 8'h80);
    bus(1, ufl_pkg::OFS_DATA, 8'h5A);
    bus(1, ufl_pkg::OFS_DIV_HIGH, 8'hC3);
    bus(1, ufl_pkg::OFS_TX_CTRL, 8'h7E);
    bus(1, ufl_pkg::OFS_LINE_FMT, 8'h03);
    bus(1, ufl_pkg::OFS_DATA, 8'h33);
    cyc(2);
    chk(div_low, 8'h5A, "div_low");
    chk(div_high, 8'hC3, "div_high");
    chk(div_frac, 8'h7E, "div_frac");
    chk(cnt[4], 1, "thr_write");
    chk(thr_byte, 8'h33, "thr_byte");
    $display("divisor test done");
  endtask
  task automatic run_tx(input int exp_n);
    int sq[$] = '{6, 5, 4, 3, 2, 1, 0, 2, 1, 0};
    cnt = '{default: 0};
    foreach (sq[i]) begin
      tx_fifo_count <= sq[i];
      rx_fifo_count <= 6 - sq[i];
      cyc(3);
    end
    chk(cnt[0], exp_n, "tx_event");
    chk(cnt[1], exp_n > 0, "rx_event");
  endtask
  task automatic t_fifo;
    cnt = '{default: 0};
    bus(1, ufl_pkg::OFS_FIFO_CTRL, 8'h36);
    cyc(3);
    chk(cnt[2] + cnt[3], 0, "fifo_clear");
    bus(1, ufl_pkg::OFS_FIFO_CTRL, 8'h1F);
    cyc(3);
    chk(cnt[2], 1, "tx_fifo_clear");
    chk(cnt[3], 1, "rx_fifo_clear");
    chk(fifo_enable, 1'b1, "fifo_enable");
    bus(0, ufl_pkg::OFS_FIFO_CTRL, 0);
    chk(rd, 0, "fifo_ctrl");
    run_tx(3);
    bus(1, ufl_pkg::OFS_FIFO_CTRL, 0);
    run_tx(0);
    $display("fifo test done");
  endtask
  task automatic t_modem;
    bus(1, ufl_pkg::OFS_MODEM_CTRL, 8'h80);
    cyc(4);
    cnt = '{default: 0};
    cyc(40);
    chk(cnt[6], 10, "baud_tick_en");
    bus(1, ufl_pkg::OFS_MODEM_CTRL, 8'h20);
    cyc(1);
    cnt = '{default: 0};
    rx_char_done <= 1'b1;
    cyc(1);
    rx_char_done <= 1'b0;
    cyc(4);
    chk(cnt[5], 1, "xon_resume");
    chk(cnt[6], 5, "baud_tick_en");
    bus(1, ufl_pkg::OFS_MODEM_CTRL, 8'h08);
    bus(1, ufl_pkg::OFS_DATA, 8'hA5);
    cyc(2);
    chk(imm_byte, 8'hA5, "imm_byte");
    chk(tx_source, ufl_pkg::UFL_TX_IMM, "tx_source");
    bus(0, ufl_pkg::OFS_MODEM_CTRL, 0);
    chk(rd[3], 1'b0, "send_imm bit");
    flow_char_pending <= 1'b1;
    cyc(2);
    chk(tx_source, ufl_pkg::UFL_TX_FLOW, "tx_source");
    flow_char_pending <= 1'b0;
    shifter_load <= 1'b1;
    cyc(1);
    shifter_load <= 1'b0;
    cyc(2);
    chk(tx_source == ufl_pkg::UFL_TX_IMM, 1'b0, "tx_source");
    bus(1, ufl_pkg::OFS_MODEM_CTRL, 8'h18);
    cyc(2);
    chk({loopback, loop_carrier_detect}, 2'b11, "loopback");
    bus(1, ufl_pkg::OFS_MODEM_CTRL, 8'h10);
    cyc(2);
    chk({loopback, loop_carrier_detect}, 2'b10, "loopback");
    bus(1, ufl_pkg::OFS_MODEM_CTRL, 0);
    $display("modem test done");
  endtask
  task automatic t_ir;
    rst(1'b1);
    bus(0, ufl_pkg::OFS_MODEM_CTRL, 0);
    chk(rd[6], 1'b1, "infrared bit");
    ir_tx_encoded <= 1'b0;
    cyc(2);
    chk(tx_pin, 1'b0, "tx_pin infrared");
    bus(1, ufl_pkg::OFS_FEATURE, 8'h10);
    cyc(5);
    chk(rx_to_ir_decoder, 1'b0, "rx_to_ir_decoder");
    send <= 1'b1;
    cyc(1);
    send <= 1'b0;
    cyc(6);
    chk(rx_to_ir_decoder, 1'b1, "rx_to_ir_decoder");
    chk(rx_to_core, 1'b0, "rx_to_core");
    bus(1, ufl_pkg::OFS_MODEM_CTRL, 0);
    bus(0, ufl_pkg::OFS_MODEM_CTRL, 0);
    chk(rd[6], 1'b0, "infrared bit");
    $display("infrared test done");
  endtask
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  initial begin
    cyc(50000);
    n_errors++;
    stop_test();
  end
  initial begin
    {hresetn, hsel, hwrite, rx_char_done, flow_char_pending, shifter_load, send} = '0;
    {infrared_strap_pin, haddr, htrans, hwdata, tx_fifo_count, rx_fifo_count} = '0;
    {tx_serial, ir_tx_encoded} = 2'b11;
    hsize = 3'h2;
    rst(1'b0);
    t_reset();
    t_fmt();
    t_div();
    t_fifo();
    t_modem();
    t_ir();
    stop_test();
  end
endmodule // tb
bind ufl_ctrl ufl_ctrl_chk #(.CNT_W(CNT_W)) u_chk (.hclk, .hresetn, .fifo_enable,
  .tx_fifo_clear, .rx_fifo_clear, .tx_event, .rx_event, .tx_fifo_count, .rx_fifo_count,
  .data_bits, .stop_mode, .tx_source, .flow_char_pending, .loopback, .loop_carrier_detect);
